// File: rtl/prss_pkg.sv
// constants and types for the phy reset and strap sequencer
// assumes a single 200 MHz system clock drives every part of the block
package prss_pkg;
  localparam int CLK_MHZ = 200;
  localparam int PWRUP_MS = 167;
  localparam int RMII_PWRUP_MS = 84;
  localparam int RST_WAIT_NS = 3000;
  localparam int DRIVE_NS = 50;
  localparam int BIT_NS = 10;
  localparam int TXCLK_HALF_NS = 20;
  localparam int J_BITS = 6;
  localparam int T_BITS = 5;
  localparam int CYC_PER_MS = CLK_MHZ * 1000;
  localparam int PWRUP_CYC = PWRUP_MS * CYC_PER_MS;
  localparam int RMII_PWRUP_CYC = RMII_PWRUP_MS * CYC_PER_MS;
  localparam int RST_WAIT_CYC = (RST_WAIT_NS * CLK_MHZ + 999) / 1000;
  localparam int DRIVE_CYC = (DRIVE_NS * CLK_MHZ + 999) / 1000;
  localparam int BIT_CYC = (BIT_NS * CLK_MHZ) / 1000;
  localparam int TXCLK_HALF_CYC = (TXCLK_HALF_NS * CLK_MHZ) / 1000;
  localparam int J_CYC = J_BITS * BIT_CYC;
  localparam int T_CYC = T_BITS * BIT_CYC;
  localparam int CNT_W = 26;
  localparam int LAT_W = 5;
  localparam int DIV_W = 3;
  typedef enum logic [2:0] {
    ST_PWR,
    ST_HOLD,
    ST_RST,
    ST_DRIVE,
    ST_RUN
  } prss_state_type;
endpackage

// File: rtl/prss_tx_if.sv
// carrier between the sequencer top and its transmit latency stage
// assumes both ends run on clk_sys
interface prss_tx_if;
  logic txclk_rise;
  logic tx_en;
  logic j_pulse;
  logic t_pulse;
  logic active;
  modport lat (input txclk_rise, input tx_en, output j_pulse,
    output t_pulse, output active);
  modport ctl (output txclk_rise, output tx_en, input j_pulse,
    input t_pulse, input active);
endinterface

// File: rtl/prss_txlat.sv
// transmit path latency stage: marks start and end code groups on the line
// assumes tx_en is already synchronised and txclk_rise is a one-cycle enable
module prss_txlat
  import prss_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic reset_n, // async reset, active low
  prss_tx_if.lat tx // enable, sampled tx_en, line markers
);
  logic enprev_r, enprev_nxt;
  logic [LAT_W-1:0] jcnt_r, jcnt_nxt;
  logic [LAT_W-1:0] tcnt_r, tcnt_nxt;
  logic j_r, j_nxt;
  logic t_r, t_nxt;
  logic act_r, act_nxt;

  always_comb begin
    enprev_nxt = enprev_r;
    jcnt_nxt = jcnt_r;
    tcnt_nxt = tcnt_r;
    j_nxt = 1'b0;
    t_nxt = 1'b0;
    act_nxt = act_r;
    if (jcnt_r != '0) begin
      jcnt_nxt = jcnt_r - LAT_W'(1);
      if (jcnt_r == LAT_W'(1)) begin
        j_nxt = 1'b1;
        act_nxt = 1'b1;
      end
    end
    if (tcnt_r != '0) begin
      tcnt_nxt = tcnt_r - LAT_W'(1);
      if (tcnt_r == LAT_W'(1)) begin
        t_nxt = 1'b1;
        act_nxt = 1'b0;
      end
    end
    if (tx.txclk_rise) begin
      enprev_nxt = tx.tx_en;
      if (tx.tx_en && !enprev_r) begin
        jcnt_nxt = LAT_W'(J_CYC);
      end
      if (!tx.tx_en && enprev_r) begin
        tcnt_nxt = LAT_W'(T_CYC);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      enprev_r <= 1'b0;
      jcnt_r <= '0;
      tcnt_r <= '0;
      j_r <= 1'b0;
      t_r <= 1'b0;
      act_r <= 1'b0;
    end else begin
      enprev_r <= enprev_nxt;
      jcnt_r <= jcnt_nxt;
      tcnt_r <= tcnt_nxt;
      j_r <= j_nxt;
      t_r <= t_nxt;
      act_r <= act_nxt;
    end
  end

  assign tx.j_pulse = j_r;
  assign tx.t_pulse = t_r;
  assign tx.active = act_r;
endmodule

// File: rtl/prss_top.sv
// phy reset and strap sequencer: strap latch, pin turnaround, tx latency,
// glitch-free receive clock switch
// assumes clk_sys is the stable reference clock; pins arrive asynchronously
//
// How it works
// - straps are latched 167 ms after power-up with the clock stable.
// - in reduced-pin mode the power-up wait shrinks to 84 ms; the 3 us reset wait does not.
// - 50 ns after a strap latch the shared pins start driving outputs.
// - straps are latched 3 us after a hard or soft reset ends.
// - the start code leaves 6 bit times after the tx clock edge past enable.
// - the end code leaves 5 bit times after the tx clock edge past disable.
// - a receive clock source switch may stretch but never shorten a phase.
module prss_top
  import prss_pkg::*;
#(
  parameter int STRAP_W = 8,
  parameter logic [CNT_W-1:0] PWRUP_CYCLES = CNT_W'(PWRUP_CYC),
  parameter logic [CNT_W-1:0] RMII_CYCLES = CNT_W'(RMII_PWRUP_CYC)
) (
  input wire logic clk_sys, // system clock, 200 MHz
  input wire logic reset_n, // power-on reset, async, active low
  input wire logic ref_clk_input_ok, // pin: reference clock is stable
  input wire logic rst_pin_n, // pin: hard reset, active low
  input wire logic soft_reset, // one-cycle soft reset request
  input wire logic rmii_strap, // pin: reduced-pin mode strap
  input wire logic [STRAP_W-1:0] strap_in, // pin input of strap pins
  input wire logic [STRAP_W-1:0] strap_drive, // core data for strap pins
  output logic [STRAP_W-1:0] strap_out, // pin output of strap pins
  output logic strap_oe, // high while strap pins are driven
  output logic [STRAP_W-1:0] strap_value, // latched strap values
  output logic rmii_mode, // latched reduced-pin mode
  output logic mgmt_ready, // management access allowed
  input wire logic tx_en, // pin: transmit enable from mac
  output logic tx_clk, // transmit clock to mac
  output logic tx_line_j, // pulse: start code on the line
  output logic tx_line_t, // pulse: end code on the line
  output logic tx_line_active, // level: frame on the line
  input wire logic rx_rec_clk, // pin: recovered receive clock
  input wire logic rx_src_sel, // 1 selects recovered receive clock
  output logic rx_clk // receive clock to mac
);
  localparam int SYNC_W = STRAP_W + 5;
  localparam logic [SYNC_W-1:0] SYNC_RST = SYNC_W'(1);

  logic [SYNC_W-1:0] sync1_r, sync2_r, sync_nxt;
  logic pin_rst_s, stable_s, rmii_s, tx_en_s, rec_s;
  logic [STRAP_W-1:0] strap_s;

  prss_state_type state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt, pwr_lim;
  logic [STRAP_W-1:0] strap_r, strap_nxt;
  logic [STRAP_W-1:0] sout_r, sout_nxt;
  logic rmii_r, rmii_nxt, oe_r, oe_nxt, ready_r, ready_nxt;

  logic [DIV_W-1:0] div_r, div_nxt;
  logic txc_r, txc_nxt, txrise;

  logic rxsrc_r, rxsrc_nxt, rxc_r, rxc_nxt, frz_r, frz_nxt;
  logic recp_r, recp_nxt, txcp_r, txcp_nxt;
  logic cur_lvl, new_lvl, new_edge;

  prss_tx_if txi ();

  always_comb begin
    sync_nxt = {strap_in, rx_rec_clk, tx_en, rmii_strap, ref_clk_input_ok,
      rst_pin_n};
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync1_r <= SYNC_RST;
      sync2_r <= SYNC_RST;
    end else begin
      sync1_r <= sync_nxt;
      sync2_r <= sync1_r;
    end
  end

  assign pin_rst_s = sync2_r[0];
  assign stable_s = sync2_r[1];
  assign rmii_s = sync2_r[2];
  assign tx_en_s = sync2_r[3];
  assign rec_s = sync2_r[4];
  assign strap_s = sync2_r[SYNC_W-1:5];

  assign pwr_lim = (rmii_s ? RMII_CYCLES : PWRUP_CYCLES) - CNT_W'(1);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r + CNT_W'(1);
    strap_nxt = strap_r;
    rmii_nxt = rmii_r;
    oe_nxt = oe_r;
    ready_nxt = ready_r;
    sout_nxt = oe_r ? strap_drive : '0;
    if (!pin_rst_s) begin
      state_nxt = ST_HOLD;
      cnt_nxt = '0;
      oe_nxt = 1'b0;
      ready_nxt = 1'b0;
    end else if (soft_reset && (state_r == ST_DRIVE || state_r == ST_RUN))
    begin
      state_nxt = ST_RST;
      cnt_nxt = '0;
      oe_nxt = 1'b0;
      ready_nxt = 1'b0;
    end else begin
      case (state_r)
        ST_PWR: begin
          // restart the wait if the clock is not stable
          if (!stable_s) begin
            cnt_nxt = '0;
          end else if (cnt_r >= pwr_lim) begin
            strap_nxt = strap_s;
            rmii_nxt = rmii_s;
            ready_nxt = 1'b1;
            cnt_nxt = '0;
            state_nxt = ST_DRIVE;
          end
        end
        ST_HOLD: begin
          cnt_nxt = '0;
          state_nxt = ST_RST;
        end
        ST_RST: begin
          if (cnt_r >= CNT_W'(RST_WAIT_CYC - 1)) begin
            strap_nxt = strap_s;
            rmii_nxt = rmii_s;
            ready_nxt = 1'b1;
            cnt_nxt = '0;
            state_nxt = ST_DRIVE;
          end
        end
        ST_DRIVE: begin
          if (cnt_r >= CNT_W'(DRIVE_CYC - 1)) begin
            oe_nxt = 1'b1;
            cnt_nxt = '0;
            state_nxt = ST_RUN;
          end
        end
        ST_RUN: begin
          cnt_nxt = cnt_r;
        end
        default: begin
          cnt_nxt = '0;
          state_nxt = ST_PWR;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_PWR;
      cnt_r <= '0;
      strap_r <= '0;
      sout_r <= '0;
      rmii_r <= 1'b0;
      oe_r <= 1'b0;
      ready_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      strap_r <= strap_nxt;
      sout_r <= sout_nxt;
      rmii_r <= rmii_nxt;
      oe_r <= oe_nxt;
      ready_r <= ready_nxt;
    end
  end

  // transmit clock divider, rise enable marks its rising edge
  always_comb begin
    div_nxt = div_r + DIV_W'(1);
    txc_nxt = txc_r;
    txrise = 1'b0;
    if (div_r == DIV_W'(TXCLK_HALF_CYC - 1)) begin
      div_nxt = '0;
      txc_nxt = !txc_r;
      txrise = !txc_r;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      div_r <= '0;
      txc_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      txc_r <= txc_nxt;
    end
  end

  assign txi.txclk_rise = txrise;
  assign txi.tx_en = tx_en_s;

  prss_txlat u_txlat (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .tx(txi.lat)
  );

  // receive clock source switch
  assign cur_lvl = rxsrc_r ? rec_s : txc_r;
  assign new_lvl = rx_src_sel ? rec_s : txc_r;
  // fresh edge of the wanted source, judged against its own last level
  assign new_edge = rx_src_sel ? (rec_s != recp_r) : (txc_r != txcp_r);

  always_comb begin
    rxsrc_nxt = rxsrc_r;
    rxc_nxt = rxc_r;
    frz_nxt = frz_r;
    recp_nxt = rec_s;
    txcp_nxt = txc_r;
    if (!frz_r && rx_src_sel == rxsrc_r) begin
      rxc_nxt = cur_lvl;
    end else if (new_edge && new_lvl == rxc_r) begin
      // hand over only on a fresh edge into the held level
      rxsrc_nxt = rx_src_sel;
      frz_nxt = 1'b0;
    end else begin
      // output frozen, so a phase can only grow
      frz_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rxsrc_r <= 1'b0;
      rxc_r <= 1'b0;
      frz_r <= 1'b0;
      recp_r <= 1'b0;
      txcp_r <= 1'b0;
    end else begin
      rxsrc_r <= rxsrc_nxt;
      rxc_r <= rxc_nxt;
      frz_r <= frz_nxt;
      recp_r <= recp_nxt;
      txcp_r <= txcp_nxt;
    end
  end

  assign strap_out = sout_r;
  assign strap_oe = oe_r;
  assign strap_value = strap_r;
  assign rmii_mode = rmii_r;
  assign mgmt_ready = ready_r;
  assign tx_clk = txc_r;
  assign tx_line_j = txi.j_pulse;
  assign tx_line_t = txi.t_pulse;
  assign tx_line_active = txi.active;
  assign rx_clk = rxc_r;
endmodule

// File: bench/prss_props.sv
// checker on the sequencer top ports
// assumes a bind into prss_top that hands on its parameters
module prss_props
  import prss_pkg::*;
#(
  parameter int STRAP_W = 8,
  parameter logic [CNT_W-1:0] PWRUP_CYCLES = CNT_W'(PWRUP_CYC),
  parameter logic [CNT_W-1:0] RMII_CYCLES = CNT_W'(RMII_PWRUP_CYC)
) (
  input wire logic clk_sys, // clock
  input wire logic reset_n, // reset
  input wire logic soft_reset, // pulse
  input wire logic [STRAP_W-1:0] strap_drive, // core data
  input wire logic [STRAP_W-1:0] strap_out, // pins
  input wire logic strap_oe, // enable
  input wire logic mgmt_ready, // level
  input wire logic tx_clk, // clock out
  input wire logic tx_line_j, // pulse
  input wire logic tx_line_t, // pulse
  input wire logic tx_line_active, // level
  input wire logic rx_clk // clock out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  oe_delay_a: assert property (
    $rose(mgmt_ready) |-> !strap_oe[*8] ##1 !strap_oe[*2] ##1 strap_oe)
    else $error("pin turnaround late or early");
  oe_ready_a: assert property (
    strap_oe |-> mgmt_ready) else $error("pins driven before latch");
  pin_follow_a: assert property (
    strap_oe && $past(strap_oe) |-> strap_out == $past(strap_drive))
    else $error("pin output wrong");
  txclk_period_a: assert property (
    $rose(tx_clk) |-> tx_clk[*4] ##1 !tx_clk[*4] ##1 tx_clk)
    else $error("tx clock period wrong");
  j_latency_a: assert property (
    tx_line_j |-> $past(tx_clk, 12) && !$past(tx_clk, 13) && tx_line_active)
    else $error("start code latency wrong");
  t_latency_a: assert property (
    tx_line_t |-> $past(tx_clk, 10) && !$past(tx_clk, 11) && !tx_line_active)
    else $error("end code latency wrong");
  soft_reset_a: assert property (
    soft_reset && mgmt_ready |=> !strap_oe && !mgmt_ready)
    else $error("soft reset not taken");
  rx_phase_a: assert property (
    $changed(rx_clk) |=> $stable(rx_clk)[*3])
    else $error("rx clock phase shortened");
endmodule

// File: bench/prss_mac_model.sv
// mac model: frames on tx enable, recovered clock
// assumes tx_clk from the block, 4 high and 4 low cycles
module prss_mac_model
(
  input wire logic clk_sys, // clock
  input wire logic tx_clk, // tx clock from block
  input wire logic [3:0] frame_len, // enable periods
  input wire logic start, // frame request
  input wire logic mgmt_ready, // access allowed flag from block
  output logic pre_done, // preamble of ones sent
  output logic tx_en, // enable to block
  output logic busy, // frame running
  output logic rx_rec_clk // recovered clock
);
  timeunit 1ns;
  timeprecision 100ps;
  logic tx_clk_d;
  logic [2:0] rc;
  int left;
  int pre_cnt;
  initial begin
    pre_done = 1'b0;
    pre_cnt = 0;
    tx_en = 1'b0;
    busy = 1'b0;
    tx_clk_d = 1'b0;
    rc = 3'h3;
    left = 0;
  end
  // enable moves just after a tx clock rise
  always @(posedge clk_sys) begin
    tx_clk_d <= tx_clk;
    rc <= rc + 3'h1;
    rx_rec_clk <= rc[2];
    // own counter, 32 high bits after the wait
    if (!mgmt_ready) begin
      pre_cnt <= 0;
      pre_done <= 1'b0;
    end else if (pre_cnt == 32) begin
      pre_done <= 1'b1;
    end else if (tx_clk && !tx_clk_d) begin
      pre_cnt <= pre_cnt + 1;
    end
    if (start) begin
      busy <= 1'b1;
      left <= frame_len;
    end else if (busy && tx_clk && !tx_clk_d) begin
      tx_en <= left > 0;
      busy <= left > 0;
      left <= left - 1;
    end
  end
endmodule

// File: bench/tb_phy_reset_strap_sequencer.sv
// bench for the sequencer: power-up, resets, tx latency
// assumes shortened power-up counts of 200 and 100 cycles
module tb_phy_reset_strap_sequencer
  import prss_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PW = 32'hc8;
  localparam int RM = 32'h64;
  logic clk_sys, reset_n, ref_clk_input_ok, rst_pin_n, soft_reset;
  logic rmii_strap, strap_oe, rmii_mode, mgmt_ready, tx_en, tx_clk;
  logic tx_line_j, tx_line_t, tx_line_active, rx_rec_clk, rx_src_sel;
  logic rx_clk, start, busy, pre_done;
  logic [7:0] strap_in, strap_drive, strap_out, strap_value;
  logic [3:0] frame_len;
  logic [31:0] rnd;
  int seed = 80675;
  int mismatches = 0;
  int check_count = 0;
  prss_top #(.PWRUP_CYCLES(26'hc8), .RMII_CYCLES(26'h64)) prss_top_i (
    .clk_sys, .reset_n, .ref_clk_input_ok, .rst_pin_n, .soft_reset,
    .rmii_strap, .strap_in, .strap_drive, .strap_out, .strap_oe,
    .strap_value, .rmii_mode, .mgmt_ready, .tx_en, .tx_clk, .tx_line_j,
    .tx_line_t, .tx_line_active, .rx_rec_clk, .rx_src_sel, .rx_clk);
  prss_mac_model prss_mac_model_i (.clk_sys, .tx_clk, .frame_len, .start,
    .mgmt_ready, .pre_done, .tx_en, .busy, .rx_rec_clk);
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    rnd <= $random(seed);
    strap_drive <= rnd[7:0];
    if (rnd[15:10] == 6'h0) rx_src_sel <= ~rx_src_sel;
  end
  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic win(input string what, input int n, input int lo,
      input int hi);
    check(what, 32'(n >= lo && n <= hi), 32'h1);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wait_ready(output int n);
    n = 0;
    while (mgmt_ready !== 1'b1 && n < 2000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask
  task automatic pwr(input logic rm);
    int n;
    int lim;
    logic [7:0] d;
    lim = rm ? RM : PW;
    @(posedge clk_sys);
    reset_n <= 1'b0;
    rmii_strap <= rm;
    strap_in <= rnd[7:0];
    ref_clk_input_ok <= 1'b0;
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    ref_clk_input_ok <= 1'b1;
    repeat (50) @(posedge clk_sys);
    // clock drop restarts the wait
    ref_clk_input_ok <= 1'b0;
    repeat (5) @(posedge clk_sys);
    ref_clk_input_ok <= 1'b1;
    wait_ready(n);
    win("power-up wait", n, lim, lim + 4);
    check("straps", 32'(strap_value), 32'(strap_in));
    check("rmii mode", 32'(rmii_mode), 32'(rm));
    repeat (12) @(posedge clk_sys);
    #1;
    check("pins driven", 32'(strap_oe), 32'h1);
    d = strap_drive;
    @(posedge clk_sys);
    #1;
    check("pin data", 32'(strap_out), 32'(d));
    $display("test power-up done");
  endtask
  task automatic hard_rst();
    int n;
    @(posedge clk_sys);
    rst_pin_n <= 1'b0;
    strap_in <= rnd[7:0];
    repeat (250) @(posedge clk_sys);
    rst_pin_n <= 1'b1;
    #1;
    check("ready in reset", 32'(mgmt_ready), 32'h0);
    wait_ready(n);
    win("reset wait", n, RST_WAIT_CYC, RST_WAIT_CYC + 6);
    check("relatch", 32'(strap_value), 32'(strap_in));
    $display("test hard reset done");
  endtask
  task automatic soft_pulse();
    @(posedge clk_sys);
    soft_reset <= 1'b1;
    @(posedge clk_sys);
    soft_reset <= 1'b0;
  endtask
  task automatic soft_rst();
    int n;
    repeat (20) @(posedge clk_sys);
    soft_pulse();
    repeat (99) @(posedge clk_sys);
    // second pulse falls in the wait and is ignored
    soft_pulse();
    #1;
    wait_ready(n);
    win("soft wait", n, RST_WAIT_CYC - 104, RST_WAIT_CYC - 96);
    $display("test soft reset done");
  endtask
  task automatic tx_frame();
    int n;
    int js;
    int ts;
    int jr;
    int tr;
    int jw;
    int tw;
    logic en_d;
    logic ck_d;
    n = 0;
    while (pre_done !== 1'b1 && n < 400) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    check("preamble sent", 32'(pre_done), 32'h1);
    @(posedge clk_sys);
    start <= 1'b1;
    frame_len <= 4'(rnd[18:16]) + 4'h1;
    @(posedge clk_sys);
    start <= 1'b0;
    n = 0;
    js = 0;
    ts = 0;
    jr = 0;
    tr = 0;
    jw = 0;
    tw = 0;
    en_d = 1'b0;
    ck_d = 1'b1;
    while ((busy || tx_line_active || ts == 0) && n < 400) begin
      @(posedge clk_sys);
      #1;
      n++;
      js += tx_line_j;
      ts += tx_line_t;
      if (tx_en === 1'b1 && !en_d) jw = 1;
      if (tx_en === 1'b0 && en_d) tw = 1;
      if (tx_clk === 1'b1 && !ck_d && jw == 1) begin
        jw = 2;
        jr = n;
      end
      if (tx_clk === 1'b1 && !ck_d && tw == 1) begin
        tw = 2;
        tr = n;
      end
      if (tx_line_j === 1'b1) check("start latency", 32'(n - jr), 32'(J_CYC));
      if (tx_line_t === 1'b1) check("end latency", 32'(n - tr), 32'(T_CYC));
      en_d = tx_en;
      ck_d = tx_clk;
    end
    check("start codes", 32'(js), 32'h1);
    check("end codes", 32'(ts), 32'h1);
    $display("test frame done");
  endtask
  initial begin
    reset_n = 1'b0;
    ref_clk_input_ok = 1'b0;
    rst_pin_n = 1'b1;
    soft_reset = 1'b0;
    rmii_strap = 1'b0;
    strap_in = 8'h0;
    strap_drive = 8'h0;
    rx_src_sel = 1'b0;
    start = 1'b0;
    frame_len = 4'h0;
    rnd = 32'h0;
    pwr(1'b1);
    pwr(1'b0);
    hard_rst();
    soft_rst();
    repeat (4) tx_frame();
    test_done();
  end
  // limit far above the expected run
  initial begin
    #200000;
    mismatches++;
    test_done();
  end
endmodule
bind prss_top prss_props #(.STRAP_W(STRAP_W), .PWRUP_CYCLES(PWRUP_CYCLES),
  .RMII_CYCLES(RMII_CYCLES)) prss_props_i (.clk_sys, .reset_n,
  .soft_reset, .strap_drive, .strap_out, .strap_oe, .mgmt_ready, .tx_clk,
  .tx_line_j, .tx_line_t, .tx_line_active, .rx_clk);
